// file: rtl/dcrma_regs.svh
// Constants for the debug command register and memory access block
`ifndef DCRMA_REGS_SVH
`define DCRMA_REGS_SVH

// ==========================================
// Serial link framing and answers
`define DCRMA_LAST_BIT    5'h10
`define DCRMA_CNT_ZERO    5'h00
`define DCRMA_CNT_ONE     5'h01
`define DCRMA_RSP_DONE    17'h0FFFF
`define DCRMA_RSP_NOTRDY  17'h10000
`define DCRMA_RSP_ILLEGAL 17'h1FFFF
`define DCRMA_RSP_ERR     17'h10001

// ==========================================
// Command opcodes
`define DCRMA_OP_CRD   12'h218
`define DCRMA_OP_CWR   12'h208
`define DCRMA_OP_SRD   12'h258
`define DCRMA_OP_SWR   12'h248
`define DCRMA_OP_READ  8'h19
`define DCRMA_OP_WRITE 8'h18
`define DCRMA_OP_DUMP  8'h1D
`define DCRMA_OP_FILL  8'h1C
`define DCRMA_OP_NOP   16'h0000
`define DCRMA_MEM_LOW  6'h00

// ==========================================
// Operand size field and pointer steps
`define DCRMA_SZ_BYTE  2'h0
`define DCRMA_SZ_WORD  2'h1
`define DCRMA_SZ_LONG  2'h2
`define DCRMA_SZ_RSVD  2'h3
`define DCRMA_INC_BYTE 32'h00000001
`define DCRMA_INC_WORD 32'h00000002
`define DCRMA_INC_LONG 32'h00000004

// ==========================================
// System register select codes
`define DCRMA_SEL_RC   4'h0
`define DCRMA_SEL_PCC  4'h1
`define DCRMA_SEL_SCR  4'h8
`define DCRMA_SEL_FAR  4'h9
`define DCRMA_SEL_VBR  4'hA
`define DCRMA_SEL_SR   4'hB
`define DCRMA_SEL_USP  4'hC
`define DCRMA_SEL_SSP  4'hD
`define DCRMA_SEL_SFC  4'hE
`define DCRMA_SEL_DFC  4'hF

// ==========================================
// Register bus map and reset values
`define DCRMA_AXI_CTRL   8'h00
`define DCRMA_AXI_STAT   8'h04
`define DCRMA_AXI_FAULT  8'h08
`define DCRMA_RESP_OKAY  2'h0
`define DCRMA_RESP_SLVER 2'h2
`define DCRMA_CTRL_RST   1'h1
`define DCRMA_SR_RST     16'h2700
`define DCRMA_WORD_RST   32'h00000000
`define DCRMA_RF_WORDS   16

`endif

// file: rtl/dcrma_pkg.sv
// Types shared by the debug command block
package dcrma_pkg;

	// ==========================================
	// Command state machine
	typedef enum logic [8:0] {
		ST_CMD  = 9'h001,
		ST_ADH  = 9'h002,
		ST_ADL  = 9'h004,
		ST_OPH  = 9'h008,
		ST_OPL  = 9'h010,
		ST_GO   = 9'h020,
		ST_MEM  = 9'h040,
		ST_RFRD = 9'h080,
		ST_RESW = 9'h100
	} dcrma_state_t;

	// ==========================================
	// Command kinds in flight
	typedef enum logic [2:0] {
		K_NONE  = 3'h0,
		K_CWR   = 3'h1,
		K_SWR   = 3'h2,
		K_READ  = 3'h3,
		K_WRITE = 3'h4,
		K_DUMP  = 3'h5,
		K_FILL  = 3'h6
	} dcrma_kind_t;

	// ==========================================
	// Memory bus request and answer
	typedef struct packed {
		logic        req;
		logic        we;
		logic [2:0]  fc;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} dcrma_mreq_t;

	typedef struct packed {
		logic        ack;
		logic        berr;
		logic [31:0] rdata;
	} dcrma_mrsp_t;

endpackage : dcrma_pkg

// file: rtl/dcrma_regfile.sv
// Core address and data register file with registered read port
`timescale 1ns/1ps
`default_nettype none
`include "dcrma_regs.svh"

module dcrma_regfile (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Write port
	input  wire logic        we,
	input  wire logic [3:0]  waddr,
	input  wire logic [31:0] wdata,
	// Read port
	input  wire logic [3:0]  raddr,
	output logic      [31:0] rdata_reg
);

	logic [31:0] mem_q [`DCRMA_RF_WORDS];

	// ==========================================
	// Storage
	always_ff @(posedge aclk) begin
		if (we) begin
			mem_q[waddr] <= wdata;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata_reg <= `DCRMA_WORD_RST;
		end else begin
			rdata_reg <= mem_q[raddr];
		end
	end

endmodule : dcrma_regfile
`default_nettype wire

// file: rtl/dcrma_core.sv
// Debug command executor for register and memory commands
`timescale 1ns/1ps
`default_nettype none
`include "dcrma_regs.svh"

module dcrma_core (
	// Clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// AXI4-Lite register slave
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// Serial debug link
	input  wire logic                 dsclk,
	input  wire logic                 dsi,
	output logic                      dso,
	// Memory bus
	output var dcrma_pkg::dcrma_mreq_t mem_req,
	input  wire dcrma_pkg::dcrma_mrsp_t mem_rsp
);

	dcrma_pkg::dcrma_state_t state_reg;
	dcrma_pkg::dcrma_kind_t  kind_reg;
	dcrma_pkg::dcrma_mreq_t  mreq_reg;
	logic        dsclk_meta_reg, dsclk_sync_reg, dsclk_prev_reg, dsi_meta_reg, dsi_sync_reg;
	logic [16:0] tx_reg, rx_reg, resp_reg;
	logic [4:0]  bit_cnt_reg;
	logic        frame_done_reg, link_en_reg, addr_err_reg, last_err_reg;
	logic [1:0]  size_reg;
	logic [3:0]  sel_reg;
	logic [31:0] addr_reg, data_reg, far_reg, rc_reg, pcc_reg, scr_reg, vbr_reg, usp_reg, ssp_reg;
	logic [15:0] lo_reg, sr_reg;
	logic [2:0]  sfc_reg, dfc_reg;
	logic        awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic [1:0]  bresp_reg, rresp_reg;
	logic [31:0] rdata_reg, rf_rdata;

	// ==========================================
	// Link sampling
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dsclk_meta_reg <= 1'h0;
			dsclk_sync_reg <= 1'h0;
			dsclk_prev_reg <= 1'h0;
			dsi_meta_reg   <= 1'h0;
			dsi_sync_reg   <= 1'h0;
		end else begin
			dsclk_meta_reg <= dsclk;
			dsclk_sync_reg <= dsclk_meta_reg;
			dsclk_prev_reg <= dsclk_sync_reg;
			dsi_meta_reg   <= dsi;
			dsi_sync_reg   <= dsi_meta_reg;
		end
	end

	wire logic dsclk_rise = dsclk_sync_reg & ~dsclk_prev_reg;
	wire logic last_bit   = bit_cnt_reg == `DCRMA_LAST_BIT;

	// ==========================================
	// Link shifter
	// seventeen bit frames
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_reg         <= `DCRMA_RSP_DONE;
			rx_reg         <= `DCRMA_RSP_DONE;
			bit_cnt_reg    <= `DCRMA_CNT_ZERO;
			frame_done_reg <= 1'h0;
		end else begin
			frame_done_reg <= link_en_reg & dsclk_rise & last_bit;
			if (!link_en_reg) begin
				bit_cnt_reg <= `DCRMA_CNT_ZERO;
				tx_reg      <= resp_reg;
			end else if (dsclk_rise) begin
				rx_reg      <= {rx_reg[15:0], dsi_sync_reg};
				tx_reg      <= {tx_reg[15:0], 1'h0};
				bit_cnt_reg <= last_bit ? `DCRMA_CNT_ZERO : bit_cnt_reg + `DCRMA_CNT_ONE;
			end else if (bit_cnt_reg == `DCRMA_CNT_ZERO) begin
				tx_reg <= resp_reg;
			end
		end
	end

	// ==========================================
	// Command decode
	wire logic [15:0] cmd      = rx_reg[15:0];
	wire logic [1:0]  cmd_size = cmd[7:6];
	wire logic        fd       = frame_done_reg;
	wire logic        size_ok  = cmd_size != `DCRMA_SZ_RSVD;
	wire logic        mem_ok   = (cmd[5:0] == `DCRMA_MEM_LOW) & size_ok;
	wire logic        is_crd   = cmd[15:4] == `DCRMA_OP_CRD;
	wire logic        is_cwr   = cmd[15:4] == `DCRMA_OP_CWR;
	wire logic        is_srd   = cmd[15:4] == `DCRMA_OP_SRD;
	wire logic        is_swr   = cmd[15:4] == `DCRMA_OP_SWR;
	wire logic        is_read  = (cmd[15:8] == `DCRMA_OP_READ) & mem_ok;
	wire logic        is_write = (cmd[15:8] == `DCRMA_OP_WRITE) & mem_ok;
	wire logic        is_dump  = (cmd[15:8] == `DCRMA_OP_DUMP) & mem_ok;
	wire logic        is_fill  = (cmd[15:8] == `DCRMA_OP_FILL) & mem_ok;
	wire logic        is_nop   = cmd == `DCRMA_OP_NOP;
	wire logic        is_long  = cmd_size == `DCRMA_SZ_LONG;
	wire logic        cmd_st   = state_reg == dcrma_pkg::ST_CMD;
	wire logic        opl_st   = state_reg == dcrma_pkg::ST_OPL;
	wire logic        in_mem   = state_reg == dcrma_pkg::ST_MEM;
	wire logic        wr_kind  = (kind_reg == dcrma_pkg::K_WRITE) | (kind_reg == dcrma_pkg::K_FILL);
	wire logic [31:0] op_word  = {data_reg[31:16], cmd};
	wire logic        rf_we    = opl_st & fd & (kind_reg == dcrma_pkg::K_CWR);
	wire logic        sys_we   = opl_st & fd & (kind_reg == dcrma_pkg::K_SWR);

	// ==========================================
	// System register read select
	// select decode
	wire logic [3:0]  ssel   = cmd[3:0];
	wire logic [31:0] sys_rd =
		(ssel == `DCRMA_SEL_RC)  ? rc_reg :
		(ssel == `DCRMA_SEL_PCC) ? pcc_reg :
		(ssel == `DCRMA_SEL_SCR) ? scr_reg :
		(ssel == `DCRMA_SEL_FAR) ? far_reg :
		(ssel == `DCRMA_SEL_VBR) ? vbr_reg :
		(ssel == `DCRMA_SEL_SR)  ? {16'h0000, sr_reg} :
		(ssel == `DCRMA_SEL_USP) ? usp_reg :
		(ssel == `DCRMA_SEL_SSP) ? ssp_reg :
		(ssel == `DCRMA_SEL_SFC) ? {29'h00000000, sfc_reg} :
		(ssel == `DCRMA_SEL_DFC) ? {29'h00000000, dfc_reg} : `DCRMA_WORD_RST;

	// ==========================================
	// Memory completion and result format
	wire logic        mem_done = in_mem & (mem_rsp.ack | addr_err_reg);
	wire logic        mem_fail = mem_rsp.berr | addr_err_reg;
	wire logic [31:0] rdat     = mem_rsp.rdata;
	wire logic [16:0] rd_first =
		(size_reg == `DCRMA_SZ_BYTE) ? {9'h000, rdat[7:0]} :
		(size_reg == `DCRMA_SZ_WORD) ? {1'h0, rdat[15:0]} : {1'h0, rdat[31:16]};
	wire logic [31:0] step =
		(size_reg == `DCRMA_SZ_BYTE) ? `DCRMA_INC_BYTE :
		(size_reg == `DCRMA_SZ_WORD) ? `DCRMA_INC_WORD : `DCRMA_INC_LONG;

	dcrma_regfile u_regfile (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.we        (rf_we),
		.waddr     (sel_reg),
		.wdata     (op_word),
		.raddr     (cmd[3:0]),
		.rdata_reg (rf_rdata)
	);

	// ==========================================
	// Command state machine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= dcrma_pkg::ST_CMD;
			kind_reg  <= dcrma_pkg::K_NONE;
			resp_reg  <= `DCRMA_RSP_DONE;
			size_reg  <= `DCRMA_SZ_BYTE;
			sel_reg   <= `DCRMA_SEL_RC;
			addr_reg  <= `DCRMA_WORD_RST;
			data_reg  <= `DCRMA_WORD_RST;
			lo_reg    <= 16'h0000;
		end else begin
			case (state_reg)
				dcrma_pkg::ST_CMD: if (fd) begin
					sel_reg  <= cmd[3:0];
					size_reg <= cmd_size;
					resp_reg <= `DCRMA_RSP_NOTRDY;
					if (is_crd) begin
						state_reg <= dcrma_pkg::ST_RFRD;
					end else if (is_cwr | is_swr) begin
						kind_reg  <= is_cwr ? dcrma_pkg::K_CWR : dcrma_pkg::K_SWR;
						state_reg <= dcrma_pkg::ST_OPH;
					end else if (is_srd) begin
						resp_reg  <= {1'h0, sys_rd[31:16]};
						lo_reg    <= sys_rd[15:0];
						state_reg <= dcrma_pkg::ST_RESW;
					end else if (is_read | is_write) begin
						kind_reg  <= is_read ? dcrma_pkg::K_READ : dcrma_pkg::K_WRITE;
						state_reg <= dcrma_pkg::ST_ADH;
					end else if (is_dump | is_fill) begin
						addr_reg  <= scr_reg;
						kind_reg  <= is_dump ? dcrma_pkg::K_DUMP : dcrma_pkg::K_FILL;
						state_reg <= is_dump ? dcrma_pkg::ST_GO :
							(is_long ? dcrma_pkg::ST_OPH : dcrma_pkg::ST_OPL);
					end else if (is_nop) begin
						resp_reg <= `DCRMA_RSP_DONE;
					end else begin
						resp_reg <= `DCRMA_RSP_ILLEGAL;
					end
				end
				dcrma_pkg::ST_ADH: if (fd) begin
					addr_reg[31:16] <= cmd;
					state_reg       <= dcrma_pkg::ST_ADL;
				end
				dcrma_pkg::ST_ADL: if (fd) begin
					addr_reg[15:0] <= cmd;
					state_reg <= (kind_reg == dcrma_pkg::K_READ) ? dcrma_pkg::ST_GO :
						(size_reg == `DCRMA_SZ_LONG) ? dcrma_pkg::ST_OPH : dcrma_pkg::ST_OPL;
				end
				dcrma_pkg::ST_OPH: if (fd) begin
					data_reg[31:16] <= cmd;
					state_reg       <= dcrma_pkg::ST_OPL;
				end
				dcrma_pkg::ST_OPL: if (fd) begin
					if (wr_kind) begin
						data_reg  <= (size_reg == `DCRMA_SZ_LONG) ? op_word : {16'h0000, cmd};
						state_reg <= dcrma_pkg::ST_GO;
					end else begin
						resp_reg  <= `DCRMA_RSP_DONE;
						state_reg <= dcrma_pkg::ST_CMD;
					end
				end
				dcrma_pkg::ST_GO: state_reg <= dcrma_pkg::ST_MEM;
				dcrma_pkg::ST_MEM: if (mem_done) begin
					state_reg <= dcrma_pkg::ST_CMD;
					if (mem_fail) begin
						resp_reg <= `DCRMA_RSP_ERR;
					end else if (wr_kind) begin
						resp_reg <= `DCRMA_RSP_DONE;
					end else begin
						resp_reg <= rd_first;
						lo_reg   <= rdat[15:0];
						if (size_reg == `DCRMA_SZ_LONG) begin
							state_reg <= dcrma_pkg::ST_RESW;
						end
					end
				end
				dcrma_pkg::ST_RFRD: begin
					resp_reg  <= {1'h0, rf_rdata[31:16]};
					lo_reg    <= rf_rdata[15:0];
					state_reg <= dcrma_pkg::ST_RESW;
				end
				dcrma_pkg::ST_RESW: if (fd) begin
					resp_reg  <= {1'h0, lo_reg};
					state_reg <= dcrma_pkg::ST_CMD;
				end
				default: state_reg <= dcrma_pkg::ST_CMD;
			endcase
		end
	end

	// ==========================================
	// System registers
	// narrow registers take low word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rc_reg  <= `DCRMA_WORD_RST;
			pcc_reg <= `DCRMA_WORD_RST;
			scr_reg <= `DCRMA_WORD_RST;
			vbr_reg <= `DCRMA_WORD_RST;
			usp_reg <= `DCRMA_WORD_RST;
			ssp_reg <= `DCRMA_WORD_RST;
			sr_reg  <= `DCRMA_SR_RST;
			sfc_reg <= 3'h0;
			dfc_reg <= 3'h0;
		end else if (mem_done) begin
			scr_reg <= addr_reg + step;
		end else if (sys_we) begin
			if (sel_reg == `DCRMA_SEL_RC)  rc_reg  <= op_word;
			if (sel_reg == `DCRMA_SEL_PCC) pcc_reg <= op_word;
			if (sel_reg == `DCRMA_SEL_SCR) scr_reg <= op_word;
			if (sel_reg == `DCRMA_SEL_VBR) vbr_reg <= op_word;
			if (sel_reg == `DCRMA_SEL_USP) usp_reg <= op_word;
			if (sel_reg == `DCRMA_SEL_SSP) ssp_reg <= op_word;
			if (sel_reg == `DCRMA_SEL_SR)  sr_reg  <= cmd;
			if (sel_reg == `DCRMA_SEL_SFC) sfc_reg <= cmd[2:0];
			if (sel_reg == `DCRMA_SEL_DFC) dfc_reg <= cmd[2:0];
		end
	end

	// ==========================================
	// Memory bus master
	wire logic aerr_next = (size_reg != `DCRMA_SZ_BYTE) & addr_reg[0];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mreq_reg     <= '0;
			addr_err_reg <= 1'h0;
			last_err_reg <= 1'h0;
		end else if (state_reg == dcrma_pkg::ST_GO) begin
			mreq_reg.req   <= ~aerr_next;
			mreq_reg.we    <= wr_kind;
			mreq_reg.fc    <= wr_kind ? dfc_reg : sfc_reg;
			mreq_reg.size  <= size_reg;
			mreq_reg.addr  <= addr_reg;
			mreq_reg.wdata <= data_reg;
			addr_err_reg   <= aerr_next;
		end else if (mem_done) begin
			mreq_reg.req <= 1'h0;
			addr_err_reg <= 1'h0;
			last_err_reg <= mem_fail;
		end
	end

	// ==========================================
	// Register bus slave
	wire logic wr_go = s_axi_awvalid & s_axi_wvalid & ~awready_reg & ~bvalid_reg;
	wire logic wr_hs = s_axi_awvalid & s_axi_wvalid & awready_reg;
	wire logic rd_go = s_axi_arvalid & ~arready_reg & ~rvalid_reg;
	wire logic rd_hs = s_axi_arvalid & arready_reg;
	wire logic aw_ctl = s_axi_awaddr == `DCRMA_AXI_CTRL;
	wire logic aw_far = s_axi_awaddr == `DCRMA_AXI_FAULT;
	wire logic [31:0] stat_word = {22'h000000, last_err_reg, state_reg};
	wire logic [31:0] rd_word;
	wire logic        rd_hit;
	assign rd_hit  = (s_axi_araddr == `DCRMA_AXI_CTRL) | (s_axi_araddr == `DCRMA_AXI_STAT)
		| (s_axi_araddr == `DCRMA_AXI_FAULT);
	assign rd_word = (s_axi_araddr == `DCRMA_AXI_CTRL) ? {31'h00000000, link_en_reg} :
		(s_axi_araddr == `DCRMA_AXI_STAT) ? stat_word :
		(s_axi_araddr == `DCRMA_AXI_FAULT) ? far_reg : `DCRMA_WORD_RST;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'h0;
			wready_reg  <= 1'h0;
			bvalid_reg  <= 1'h0;
			bresp_reg   <= `DCRMA_RESP_OKAY;
			arready_reg <= 1'h0;
			rvalid_reg  <= 1'h0;
			rresp_reg   <= `DCRMA_RESP_OKAY;
			rdata_reg   <= `DCRMA_WORD_RST;
			link_en_reg <= `DCRMA_CTRL_RST;
		end else begin
			awready_reg <= wr_go;
			wready_reg  <= wr_go;
			arready_reg <= rd_go;
			if (wr_hs) begin
				bvalid_reg <= 1'h1;
				bresp_reg  <= (aw_ctl | aw_far) ? `DCRMA_RESP_OKAY : `DCRMA_RESP_SLVER;
				if (aw_ctl & s_axi_wstrb[0]) link_en_reg <= s_axi_wdata[0];
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'h0;
			end
			if (rd_hs) begin
				rvalid_reg <= 1'h1;
				rdata_reg  <= rd_word;
				rresp_reg  <= rd_hit ? `DCRMA_RESP_OKAY : `DCRMA_RESP_SLVER;
			end else if (s_axi_rready) begin
				rvalid_reg <= 1'h0;
			end
		end
	end

	// Fault address byte lanes
	for (genvar gi = 0; gi < 4; gi++) begin : g_far
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				far_reg[gi*8 +: 8] <= 8'h00;
			end else if (wr_hs & aw_far & s_axi_wstrb[gi]) begin
				far_reg[gi*8 +: 8] <= s_axi_wdata[gi*8 +: 8];
			end
		end
	end

	// ==========================================
	// Outputs
	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;
	assign dso           = tx_reg[16];
	assign mem_req       = mreq_reg;

	// ==========================================
	// Assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	wire logic cmd_ill = fd & cmd_st & ~(is_crd | is_cwr | is_srd | is_swr | is_read | is_write
		| is_dump | is_fill | is_nop);

	a_dump_ptr_step: assert property (mem_done & ~wr_kind |=> scr_reg == $past(addr_reg) + $past(step)) else $error("read pointer not advanced");
	a_fill_ptr_step: assert property (mem_done & wr_kind |=> scr_reg == $past(addr_reg) + $past(step)) else $error("write pointer not advanced");
	a_read_err_code: assert property (mem_done & mem_fail & ~wr_kind |=> resp_reg == `DCRMA_RSP_ERR) else $error("read error pattern wrong");
	a_write_ok_code: assert property (mem_done & ~mem_fail & wr_kind |=> resp_reg == `DCRMA_RSP_DONE) else $error("write status wrong");
	a_byte_upper_clr: assert property (mem_done & ~mem_fail & ~wr_kind & (size_reg == `DCRMA_SZ_BYTE) |=> resp_reg[16:8] == 9'h000) else $error("byte upper not clear");
	a_busy_not_ready: assert property (in_mem |-> resp_reg == `DCRMA_RSP_NOTRDY) else $error("busy answer not not-ready");
	a_far_read_only: assert property (sys_we & (sel_reg == `DCRMA_SEL_FAR) & ~wr_hs |=> $stable(far_reg)) else $error("fault address written");
	a_illegal_reply: assert property (cmd_ill |=> resp_reg == `DCRMA_RSP_ILLEGAL && state_reg == dcrma_pkg::ST_CMD) else $error("illegal answer missing");
	a_sr_zero_ext: assert property (fd & cmd_st & is_srd & (ssel == `DCRMA_SEL_SR) |=> resp_reg == `DCRMA_RSP_NOTRDY - `DCRMA_RSP_NOTRDY && lo_reg == $past(sr_reg)) else $error("status read not zero extended");
	a_low_word_next: assert property (fd & (state_reg == dcrma_pkg::ST_RESW) |=> resp_reg == {1'h0, $past(lo_reg)} ##0 state_reg == dcrma_pkg::ST_CMD) else $error("low word order wrong");

	c_dump_done: cover property (mem_done & ~mem_fail & (kind_reg == dcrma_pkg::K_DUMP));
	c_fill_done: cover property (mem_done & ~mem_fail & (kind_reg == dcrma_pkg::K_FILL));
	c_core_read: cover property ((state_reg == dcrma_pkg::ST_RFRD) ##1 (state_reg == dcrma_pkg::ST_RESW));
	c_illegal: cover property (cmd_ill);

endmodule : dcrma_core
`default_nettype wire

// file: verif/dcrma_host.sv
// Host model that drives the serial debug link
`timescale 1ns/1ps
`default_nettype none

module dcrma_host (
	// Clock
	input  wire logic aclk,
	// Serial link
	output logic      dsclk,
	output logic      dsi,
	input  wire logic dso
);
	initial begin
		dsclk = 1'h0;
		dsi   = 1'h1;
	end

	// ==========================================
	// One frame, MSB first, clock idles low
	// seventeen bits
	task automatic xfer(input logic [16:0] w, output logic [16:0] r);
		for (int i = 16; i >= 0; i--) begin
			dsi <= w[i];
			repeat (4) @(posedge aclk);
			r[i] = dso;
			dsclk <= 1'h1;
			repeat (4) @(posedge aclk);
			dsclk <= 1'h0;
		end
		dsi <= ~w[0];
		repeat (16) @(posedge aclk);
	endtask : xfer
endmodule : dcrma_host

`default_nettype wire

// file: verif/dcrma_core_tb.sv
// Self-checking bench for the debug command block
`timescale 1ns/1ps
`default_nettype none

module dcrma_core_tb;
	logic                   aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic                   awready, wready, bvalid, arready, rvalid, dsclk, dsi, dso;
	logic [7:0]             awaddr, araddr;
	logic [31:0]            wdata, rdata, la, ld;
	logic [1:0]             bresp, rresp;
	logic [16:0]            got;
	dcrma_pkg::dcrma_mreq_t mreq;
	dcrma_pkg::dcrma_mrsp_t mrsp;
	int                     failures, n_tests, cyc;
	// dump after read, fill after write
	logic [16:0] cmd [38] = '{17'h00000, 17'h02081, 17'h01234, 17'h05678, 17'h02181, 17'h00000,
		17'h00000, 17'h0248E, 17'h0FFFF, 17'h00005, 17'h0258E, 17'h00000, 17'h00000, 17'h02489,
		17'h01111, 17'h02222, 17'h02589, 17'h00000, 17'h00000, 17'h01940, 17'h00000, 17'h00010,
		17'h01D00, 17'h00000, 17'h01880, 17'h00000, 17'h00020, 17'h0DEAD, 17'h0BEEF, 17'h01C40,
		17'h01357, 17'h00000, 17'h01980, 17'h08000, 17'h00000, 17'h00000, 17'h0FFF0, 17'h00000};
	logic [16:0] rsp [38] = '{17'h0FFFF, 17'h0FFFF, 17'h10000, 17'h10000, 17'h0FFFF, 17'h01234,
		17'h05678, 17'h0FFFF, 17'h10000, 17'h10000, 17'h0FFFF, 17'h00000, 17'h00005, 17'h0FFFF,
		17'h10000, 17'h10000, 17'h0FFFF, 17'h000C0, 17'h0FFEE, 17'h0FFFF, 17'h10000, 17'h10000,
		17'h05A4A, 17'h00048, 17'h0FFFF, 17'h10000, 17'h10000, 17'h10000, 17'h10000, 17'h0FFFF,
		17'h10000, 17'h0FFFF, 17'h0FFFF, 17'h10000, 17'h10000, 17'h10001, 17'h0FFFF, 17'h1FFFF};

	dcrma_core dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dsclk(dsclk),
		.dsi(dsi), .dso(dso), .mem_req(mreq), .mem_rsp(mrsp));
	dcrma_host host (.aclk(aclk), .dsclk(dsclk), .dsi(dsi), .dso(dso));

	// ==========================================
	// Clock, watchdog and memory responder
	always #50 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			test_done();
		end
	end
	always @(posedge aclk) begin
		mrsp.ack   <= mreq.req && !mrsp.ack;
		mrsp.berr  <= mreq.addr[31];
		mrsp.rdata <= {mreq.addr[15:0], mreq.addr[15:0] ^ 16'h5A5A};
		if (mreq.req && !mrsp.ack) chk(mreq.fc, mreq.we ? 3'h0 : 3'h5);
		if (mrsp.ack && mreq.we) begin
			la <= mreq.addr;
			ld <= mreq.wdata;
		end
	end

	// ==========================================
	// Shared tasks
	task automatic chk(input logic [33:0] s, input logic [33:0] e);
		n_tests++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'h1;
		wvalid  <= 1'h1;
		do @(posedge aclk); while (!(awready && wready));
		awvalid <= 1'h0;
		wvalid  <= 1'h0;
		bready  <= 1'h1;
		do @(posedge aclk); while (!bvalid);
		bready <= 1'h0;
		chk(bresp, 2'h0);
	endtask : axw
	task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
		araddr  <= a;
		arvalid <= 1'h1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'h0;
		rready  <= 1'h1;
		do @(posedge aclk); while (!rvalid);
		rready <= 1'h0;
		chk(rdata, d);
		chk(rresp, rs);
	endtask : axr
	task automatic test_done();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	// ==========================================
	// Main sequence
	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (3) @(posedge aclk);
		axr(8'h00, 32'h00000001, 2'h0);
		axr(8'h0C, 32'h00000000, 2'h2);
		axw(8'h08, 32'h00C0FFEE);
		for (int i = 0; i < 38; i++) begin
			host.xfer(cmd[i], got);
			chk(got, rsp[i]);
		end
		chk(la, 32'h00000024);
		chk(ld[15:0], 16'h1357);
		axr(8'h04, 32'h00000201, 2'h0);
		// Link disabled, frame ignored
		axw(8'h00, 32'h00000000);
		host.xfer(17'h0FFF0, got);
		chk(got, 17'h00000);
		// Mid-run reset
		aresetn <= 1'h0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (3) @(posedge aclk);
		chk({bvalid, rvalid, awready, arready, mreq.req, dso}, 6'h00);
		axr(8'h00, 32'h00000001, 2'h0);
		// Status register read after reset
		host.xfer(17'h0258B, got);
		chk(got, 17'h0FFFF);
		host.xfer(17'h00000, got);
		chk(got, 17'h00000);
		host.xfer(17'h00000, got);
		chk(got, 17'h02700);
		test_done();
	end
endmodule : dcrma_core_tb

`default_nettype wire
